// ---- logic/cspt_pkg.sv ----
// Constants shared by the core storage pattern test block.
package cspt_pkg;
    localparam int unsigned RA_W            = 8;
    localparam int unsigned DW              = 32;
    localparam int unsigned WORD_W          = 36;
    localparam int unsigned BYTE_W          = 8;
    localparam int unsigned NBYTES          = 4;
    localparam int unsigned PAR_LSB         = 32;

    localparam logic [7:0]  OFF_CTRL        = 8'h00;
    localparam logic [7:0]  OFF_CMD         = 8'h04;
    localparam logic [7:0]  OFF_ROUTINE     = 8'h08;
    localparam logic [7:0]  OFF_IC          = 8'h0C;
    localparam logic [7:0]  OFF_STATUS      = 8'h10;
    localparam logic [7:0]  OFF_IAR         = 8'h14;
    localparam logic [7:0]  OFF_SAR         = 8'h18;
    localparam logic [7:0]  OFF_SDR_DATA    = 8'h1C;
    localparam logic [7:0]  OFF_SDR_PAR     = 8'h20;
    localparam logic [7:0]  OFF_IRQ_STAT    = 8'h24;
    localparam logic [7:0]  OFF_IRQ_EN      = 8'h28;
    localparam logic [7:0]  OFF_IRQ_CLR     = 8'h2C;

    localparam int unsigned CTRL_W          = 7;
    localparam int unsigned CTRL_SEL_LSB    = 0;
    localparam int unsigned CTRL_SEL_W      = 3;
    localparam int unsigned CTRL_WRITE_BIT  = 3;
    localparam int unsigned CTRL_STOPCHK_BIT = 4;
    localparam int unsigned CTRL_REPEAT_BIT = 5;
    localparam int unsigned CTRL_BUMP_BIT   = 6;
    localparam logic [6:0]  CTRL_RESET      = 7'h04;

    localparam int unsigned CMD_START_BIT   = 0;
    localparam int unsigned CMD_STOP_BIT    = 1;

    localparam int unsigned ROUTINE_W       = 10;
    localparam logic [9:0]  ROUTINE_LOOP    = 10'd202;

    localparam logic [2:0]  SEL_ONES        = 3'd0;
    localparam logic [2:0]  SEL_ZEROS       = 3'd1;
    localparam logic [2:0]  SEL_WORST       = 3'd2;
    localparam logic [2:0]  SEL_RWORST      = 3'd3;
    localparam logic [2:0]  SEL_PROCESS     = 3'd4;
    localparam logic [2:0]  NUM_PATTERNS    = 3'd4;
    localparam logic [31:0] WORST_WORD      = 32'hAAAA_AAAA;

    localparam int unsigned STAT_TEST_BIT   = 0;
    localparam int unsigned STAT_RUN_BIT    = 1;
    localparam int unsigned STAT_HALT_BIT   = 2;
    localparam int unsigned STAT_LOOP_BIT   = 3;
    localparam int unsigned STAT_PWR_BIT    = 4;

    localparam int unsigned NEV             = 4;
    localparam int unsigned EV_PERR         = 0;
    localparam int unsigned EV_HALT         = 1;
    localparam int unsigned EV_PASS         = 2;
    localparam int unsigned EV_UV           = 3;

    localparam int unsigned CLK_NS          = 50;
    localparam int unsigned SET_TAP_NS      = 100;
    localparam int unsigned STROBE_TAP_NS   = 350;
    localparam int unsigned RESET_TAP_NS    = 300;
    localparam int unsigned ONESHOT_NS      = 450;
    localparam int unsigned UV_STOP_MS      = 20;
    localparam int unsigned SET_CYC         = (SET_TAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned STROBE_CYC      = (STROBE_TAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RESET_CYC       = (RESET_TAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ONESHOT_CYC     = (ONESHOT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned UV_STOP_CYC_DEF = (UV_STOP_MS * 1000000) / CLK_NS;
    localparam int unsigned TCNT_W          = 5;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_HALT = 3'b100
    } cspt_state_t;
endpackage : cspt_pkg

// ---- logic/cspt_cycle_timer.sv ----
// Storage cycle timing: select, strobe and reset pulses.
`timescale 1ns/1ps
module cspt_cycle_timer (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic go_i,
    input  wire logic read_i,
    output logic      busy_o,
    output logic      select_o,
    output logic      strobe_o,
    output logic      reset_pulse_o
);
    import cspt_pkg::*;

    logic [TCNT_W-1:0] set_cnt_reg;
    logic [TCNT_W-1:0] rst_cnt_reg;
    logic [TCNT_W-1:0] os_cnt_reg;
    logic              rst_run_reg;
    logic              read_reg;

    wire set_tap    = busy_o && !select_o && !rst_run_reg && (set_cnt_reg == TCNT_W'(SET_CYC - 1));
    wire strobe_tap = busy_o && (set_cnt_reg == TCNT_W'(STROBE_CYC - 1));
    wire os_active  = read_reg && (os_cnt_reg != '0);
    wire reset_tap  = rst_run_reg && (rst_cnt_reg >= TCNT_W'(RESET_CYC - 1)) && !os_active;

    generate
        if (SET_CYC < 1 || STROBE_CYC >= (1 << TCNT_W) || RESET_CYC >= (1 << TCNT_W)) begin : g_chk
            $error("Taps overflow counter.");
        end
    endgenerate

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_o        <= 1'b0;
            read_reg      <= 1'b0;
            set_cnt_reg   <= '0;
            os_cnt_reg    <= '0;
        end else if (go_i && !busy_o) begin
            busy_o        <= 1'b1;
            read_reg      <= read_i;
            set_cnt_reg   <= '0;
            os_cnt_reg    <= TCNT_W'(ONESHOT_CYC);
        end else begin
            set_cnt_reg   <= busy_o ? set_cnt_reg + 1'b1 : set_cnt_reg;
            os_cnt_reg    <= (os_cnt_reg != '0) ? os_cnt_reg - 1'b1 : os_cnt_reg;
            busy_o        <= busy_o && !reset_tap;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            select_o      <= 1'b0;
            strobe_o      <= 1'b0;
            reset_pulse_o <= 1'b0;
            rst_run_reg   <= 1'b0;
            rst_cnt_reg   <= '0;
        end else begin
            strobe_o      <= strobe_tap;
            reset_pulse_o <= reset_tap;
            select_o      <= set_tap ? 1'b1 : (reset_tap ? 1'b0 : select_o);
            rst_run_reg   <= set_tap ? 1'b1 : (reset_tap ? 1'b0 : rst_run_reg);
            rst_cnt_reg   <= set_tap ? '0 : (rst_run_reg ? rst_cnt_reg + 1'b1 : rst_cnt_reg);
        end
    end
endmodule : cspt_cycle_timer

// ---- logic/cspt_core.sv ----
// Core storage pattern test sequencer with its register port and interrupt.
//
// Overview of operation
// - Four patterns: ones, zeros, worst, reverse worst.
// - Fifth position is processing; test light off.
// - Write lever writes pattern; data register shows ones.
// - Lever normal: read each word and regenerate it.
// - Stop-on-check halts; address register holds failing address.
// - Each start after halt resumes at next location.
// - Word: four bytes then four byte parity bits.
// - Check stop keeps failing address and bad data.
// - Bump address bit held low targets bump storage.
// - Repeat plus routine 202 loops on one address.
// - Set, reset and strobe timing from delay taps.
// - Reset taps run from the set timing.
// - 450 ns one-shot blocks early read reset.
// - Undervoltage stops cycling within 20 ms, drops power.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
module cspt_core #(
    parameter int unsigned AW          = 16,
    parameter int unsigned UV_STOP_CYC = cspt_pkg::UV_STOP_CYC_DEF
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic [cspt_pkg::RA_W-1:0]     reg_addr_i,
    input  wire logic [cspt_pkg::DW-1:0]       reg_wdata_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    output logic      [cspt_pkg::DW-1:0]       reg_rdata_o,
    output logic                               irq_o,
    output logic                               test_light_o,
    input  wire logic                          uv6_i,
    output logic                               power_drop_o,
    output logic      [AW-1:0]                 mem_addr_o,
    output logic      [cspt_pkg::WORD_W-1:0]   mem_wdata_o,
    output logic                               mem_write_o,
    output logic                               mem_select_o,
    output logic                               mem_strobe_o,
    output logic                               mem_reset_o,
    input  wire logic [cspt_pkg::WORD_W-1:0]   mem_rdata_i
);
    import cspt_pkg::*;

    generate
        if (AW < 2 || AW > DW || UV_STOP_CYC < 1) begin : g_chk
            $error("Bad parameters.");
        end
    endgenerate

    // Builds a stored word with odd parity per byte, parity bits above the data.
    function automatic logic [WORD_W-1:0] make_word(input logic [DW-1:0] d);
        logic [WORD_W-1:0] w;
        w = {4'h0, d};
        for (int i = 0; i < NBYTES; i++) begin
            w[PAR_LSB + i] = ~(^d[i*BYTE_W +: BYTE_W]);
        end
        return w;
    endfunction : make_word

    // Flags a stored word whose parity bits disagree with its bytes.
    function automatic logic bad_parity(input logic [WORD_W-1:0] w);
        return make_word(w[DW-1:0]) != w;
    endfunction : bad_parity

    cspt_state_t           state_reg;
    cspt_state_t           state_next;
    logic [CTRL_W-1:0]     ctrl_reg;
    logic [ROUTINE_W-1:0]  routine_reg;
    logic [AW-1:0]         ic_reg;
    logic [AW-1:0]         scan_reg;
    logic [AW-1:0]         iar_reg;
    logic [WORD_W-1:0]     sdr_reg;
    logic                  loop_reg;
    logic                  go_reg;
    logic                  cyc_read_reg;
    logic                  cyc_live_reg;
    logic                  uv_reg;
    logic [31:0]           uv_cnt_reg;
    logic [NEV-1:0]        ev_stat_reg;
    logic [NEV-1:0]        ev_en_reg;
    logic                  t_busy;
    logic                  t_select;
    logic                  t_strobe;
    logic                  t_reset;

    wire [CTRL_SEL_W-1:0] sel      = ctrl_reg[CTRL_SEL_LSB +: CTRL_SEL_W];
    wire       wr_lever  = ctrl_reg[CTRL_WRITE_BIT];
    wire       stop_chk  = ctrl_reg[CTRL_STOPCHK_BIT];
    wire       rep_sw    = ctrl_reg[CTRL_REPEAT_BIT];
    wire       bump_sw   = ctrl_reg[CTRL_BUMP_BIT];
    wire       is_test   = sel < NUM_PATTERNS;
    wire       wr_ctrl   = reg_wr_i && (reg_addr_i == OFF_CTRL);
    wire       wr_cmd    = reg_wr_i && (reg_addr_i == OFF_CMD);
    wire       start_cmd = wr_cmd && reg_wdata_i[CMD_START_BIT];
    wire       stop_cmd  = wr_cmd && reg_wdata_i[CMD_STOP_BIT];
    wire       loop_ok   = rep_sw && (routine_reg == ROUTINE_LOOP);
    wire       in_run    = state_reg == ST_RUN;
    wire       in_halt   = state_reg == ST_HALT;
    wire       run_ok    = loop_reg ? rep_sw : is_test;
    wire       launch    = in_run && run_ok && !t_busy && !go_reg && !cyc_live_reg && !uv_reg && !stop_cmd;
    wire       cyc_end   = cyc_live_reg && t_reset;
    wire       chk_end   = cyc_end && cyc_read_reg && in_run && !loop_reg;
    wire       err_word  = chk_end && bad_parity(sdr_reg);
    wire       err_stop  = err_word && stop_chk;
    wire       scan_step = (cyc_end && in_run && !loop_reg && !err_stop) || (in_halt && start_cmd);
    wire       pass_done = cyc_end && in_run && !loop_reg && !err_stop && (scan_reg == '1);
    wire [AW-1:0] cyc_addr_raw = loop_reg ? ic_reg : scan_reg;
    wire [AW-1:0] cyc_addr = bump_sw ? {1'b0, cyc_addr_raw[AW-2:0]} : cyc_addr_raw;

    // Pattern for the next write cycle; worst pattern alternates with the address.
    wire [DW-1:0] worst    = cyc_addr[0] ? ~WORST_WORD : WORST_WORD;
    wire [DW-1:0] pat_data = (sel == SEL_ONES)   ? '1 :
                             (sel == SEL_ZEROS)  ? '0 :
                             (sel == SEL_WORST)  ? worst :
                                                   ~worst;

    wire [NEV-1:0] ev_set = {uv6_i && !uv_reg, pass_done, err_stop, err_word};
    wire [NEV-1:0] ev_clr = (reg_wr_i && (reg_addr_i == OFF_IRQ_CLR)) ? reg_wdata_i[NEV-1:0] : '0;

    wire [DW-1:0] status_word = DW'({power_drop_o, loop_reg, in_halt, in_run, test_light_o});
    wire [DW-1:0] rd_mux =
        (reg_addr_i == OFF_CTRL)     ? DW'(ctrl_reg) :
        (reg_addr_i == OFF_ROUTINE)  ? DW'(routine_reg) :
        (reg_addr_i == OFF_IC)       ? DW'(ic_reg) :
        (reg_addr_i == OFF_STATUS)   ? status_word :
        (reg_addr_i == OFF_IAR)      ? DW'(iar_reg) :
        (reg_addr_i == OFF_SAR)      ? DW'(mem_addr_o) :
        (reg_addr_i == OFF_SDR_DATA) ? sdr_reg[DW-1:0] :
        (reg_addr_i == OFF_SDR_PAR)  ? DW'(sdr_reg[WORD_W-1:PAR_LSB]) :
        (reg_addr_i == OFF_IRQ_STAT) ? DW'(ev_stat_reg) :
        (reg_addr_i == OFF_IRQ_EN)   ? DW'(ev_en_reg) :
                                       '0;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_cmd && !uv_reg && (loop_ok || is_test)) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_cmd || !run_ok || uv_reg) begin
                    state_next = ST_IDLE;
                end else if (err_stop) begin
                    state_next = ST_HALT;
                end
            end
            ST_HALT: begin
                if (stop_cmd || !is_test) begin
                    state_next = ST_IDLE;
                end else if (start_cmd && !uv_reg) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            loop_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            loop_reg  <= (state_reg == ST_IDLE && start_cmd) ? loop_ok : loop_reg;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_reg    <= CTRL_RESET;
            routine_reg <= '0;
            ic_reg      <= '0;
            ev_en_reg   <= '0;
        end else begin
            ctrl_reg    <= wr_ctrl ? reg_wdata_i[CTRL_W-1:0] : ctrl_reg;
            routine_reg <= (reg_wr_i && reg_addr_i == OFF_ROUTINE) ? reg_wdata_i[ROUTINE_W-1:0] : routine_reg;
            ic_reg      <= (reg_wr_i && reg_addr_i == OFF_IC) ? reg_wdata_i[AW-1:0] : ic_reg;
            ev_en_reg   <= (reg_wr_i && reg_addr_i == OFF_IRQ_EN) ? reg_wdata_i[NEV-1:0] : ev_en_reg;
        end
    end

    // Storage cycle launch; address and write flag are frozen for the whole cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            go_reg       <= 1'b0;
            cyc_read_reg <= 1'b0;
            cyc_live_reg <= 1'b0;
            mem_addr_o   <= '0;
            mem_write_o  <= 1'b0;
        end else begin
            go_reg       <= launch;
            cyc_read_reg <= launch ? !wr_lever : cyc_read_reg;
            cyc_live_reg <= launch ? 1'b1 : (t_reset ? 1'b0 : cyc_live_reg);
            mem_addr_o   <= launch ? cyc_addr : mem_addr_o;
            mem_write_o  <= launch ? wr_lever : mem_write_o;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_wdata_o <= '0;
            sdr_reg     <= '0;
        end else begin
            if (launch && wr_lever) begin
                mem_wdata_o <= make_word(pat_data);
            end else if (t_strobe && cyc_live_reg && cyc_read_reg) begin
                mem_wdata_o <= mem_rdata_i;
            end
            if (wr_lever && !in_halt) begin
                sdr_reg <= '1;
            end else if (t_strobe && cyc_live_reg && cyc_read_reg && !in_halt) begin
                sdr_reg <= mem_rdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scan_reg <= '0;
            iar_reg  <= '0;
        end else begin
            scan_reg <= (state_reg == ST_IDLE && start_cmd) ? '0 :
                        (scan_step ? scan_reg + 1'b1 : scan_reg);
            iar_reg  <= err_stop ? mem_addr_o : iar_reg;
        end
    end

    // Undervoltage: no new cycle starts; power drops once the cycle in flight ends.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            uv_reg       <= 1'b0;
            uv_cnt_reg   <= '0;
            power_drop_o <= 1'b0;
        end else begin
            uv_reg       <= uv_reg || uv6_i;
            uv_cnt_reg   <= (uv_reg && uv_cnt_reg < 32'(UV_STOP_CYC)) ? uv_cnt_reg + 1'b1 : uv_cnt_reg;
            power_drop_o <= power_drop_o ||
                            (uv_reg && (!t_busy || uv_cnt_reg >= 32'(UV_STOP_CYC - 1)));
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ev_stat_reg  <= '0;
            irq_o        <= 1'b0;
            test_light_o <= 1'b0;
            reg_rdata_o  <= '0;
        end else begin
            ev_stat_reg  <= (ev_stat_reg & ~ev_clr) | ev_set;
            irq_o        <= |(ev_stat_reg & ev_en_reg);
            test_light_o <= is_test;
            reg_rdata_o  <= reg_rd_i ? rd_mux : '0;
        end
    end

    cspt_cycle_timer u_timer (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .go_i          (go_reg),
        .read_i        (cyc_read_reg),
        .busy_o        (t_busy),
        .select_o      (t_select),
        .strobe_o      (t_strobe),
        .reset_pulse_o (t_reset)
    );

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_select_o <= 1'b0;
            mem_strobe_o <= 1'b0;
            mem_reset_o  <= 1'b0;
        end else begin
            mem_select_o <= t_select;
            mem_strobe_o <= t_strobe;
            mem_reset_o  <= t_reset;
        end
    end
endmodule : cspt_core

// ---- sim/cspt_core_assertions.sv ----
// Port checks for the storage pattern test block.
`timescale 1ns/1ps
module cspt_core_chk
    import cspt_pkg::*;
#(
    parameter int unsigned AW          = 16,
    parameter int unsigned UV_STOP_CYC = 20
) (
    input wire logic                        clk_i,
    input wire logic                        rst_i,
    input wire logic [cspt_pkg::RA_W-1:0]   reg_addr_i,
    input wire logic [cspt_pkg::DW-1:0]     reg_wdata_i,
    input wire logic                        reg_wr_i,
    input wire logic                        test_light_o,
    input wire logic                        uv6_i,
    input wire logic                        power_drop_o,
    input wire logic [AW-1:0]               mem_addr_o,
    input wire logic [cspt_pkg::WORD_W-1:0] mem_wdata_o,
    input wire logic                        mem_write_o,
    input wire logic                        mem_select_o,
    input wire logic                        mem_strobe_o,
    input wire logic                        mem_reset_o
);
    localparam int UV_MAX = UV_STOP_CYC + 16;
    logic [CTRL_W-1:0] ctrl_reg;
    wire logic         ctrl_wr = reg_wr_i && reg_addr_i == OFF_CTRL;
    wire logic [2:0]   wsel    = reg_wdata_i[2:0];
    wire logic [31:0]  wd      = mem_wdata_o[31:0];
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            ctrl_reg <= CTRL_RESET;
        else if (ctrl_wr)
            ctrl_reg <= reg_wdata_i[CTRL_W-1:0];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_light_on: assert property (ctrl_wr && wsel < SEL_PROCESS ##1 !ctrl_wr |=> test_light_o)
        else $error("light off");
    a_light_off: assert property (ctrl_wr && wsel >= SEL_PROCESS ##1 !ctrl_wr |=> !test_light_o)
        else $error("light on");
    a_ones_data: assert property (ctrl_reg[2:0] == SEL_ONES && mem_write_o && mem_select_o |-> wd == '1)
        else $error("not ones");
    a_word_parity: assert property (mem_write_o && mem_select_o |->
        mem_wdata_o[35:32] == {~^wd[31:24], ~^wd[23:16], ~^wd[15:8], ~^wd[7:0]})
        else $error("bad parity");
    a_strobe_tap: assert property ($rose(mem_select_o) |-> ##5 mem_strobe_o)
        else $error("strobe late");
    a_strobe_pulse: assert property (mem_strobe_o |=> !mem_strobe_o)
        else $error("strobe long");
    a_reset_tap: assert property ($rose(mem_select_o) |->
        ##6 (mem_reset_o == mem_write_o) ##2 (mem_reset_o != mem_write_o))
        else $error("reset late");
    a_early_reset: assert property ($rose(mem_select_o) && !mem_write_o |=> !mem_reset_o [*7])
        else $error("early reset");
    a_bump_low: assert property (ctrl_reg[CTRL_BUMP_BIT] && mem_select_o |-> !mem_addr_o[AW-1])
        else $error("bump bit high");
    a_uv_stop: assert property ($rose(uv6_i) |-> ##[0:UV_MAX] power_drop_o)
        else $error("no power drop");
    a_power_hold: assert property (power_drop_o |=> power_drop_o)
        else $error("drop released");
endmodule : cspt_core_chk

bind cspt_core cspt_core_chk #(.AW(AW), .UV_STOP_CYC(UV_STOP_CYC)) u_chk (.*);

// ---- sim/cspt_store_model.sv ----
// Behavioural core storage array with destructive read.
`timescale 1ns/1ps
module cspt_store_model #(
    parameter int unsigned AW = 6
) (
    input  wire logic          clk_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [35:0]   wdata_i,
    input  wire logic          write_i,
    input  wire logic          select_i,
    input  wire logic          strobe_i,
    input  wire logic          reset_i,
    input  wire logic          inject_i,
    input  wire logic [AW-1:0] inject_addr_i,
    output logic      [35:0]   rdata_o
);
    logic [35:0] mem [2**AW];
    logic [35:0] last_reg;
    initial begin
        last_reg = 36'h5_a5a5_a5a5;
        for (int i = 0; i < 2 ** AW; i++)
            mem[i] = 36'h5_a5a5_a5a5;
    end
    always @(posedge clk_i) begin
        if (select_i)
            last_reg <= mem[addr_i];
        if (strobe_i && !write_i)
            mem[addr_i] <= 36'h0_0000_0000;
        if (reset_i)
            mem[addr_i] <= wdata_i;
        if (inject_i)
            mem[inject_addr_i] <= mem[inject_addr_i] ^ 36'h0_0000_0001;
    end
    assign rdata_o = select_i ? mem[addr_i] : ~last_reg;
endmodule : cspt_store_model

// ---- sim/cspt_core_tb_top.sv ----
// Bench for the storage pattern test block.
`timescale 1ns/1ps
module cspt_core_tb_top;
    import cspt_pkg::*;
    localparam int unsigned AW  = 6;
    localparam int unsigned UVC = 20;
    localparam int          NW  = 2 ** AW;
    logic              clk_i, rst_i, reg_wr_i, reg_rd_i, uv6_i, irq_o, test_light_o, power_drop_o;
    logic              mem_write_o, mem_select_o, mem_strobe_o, mem_reset_o, inject;
    logic [RA_W-1:0]   reg_addr_i;
    logic [DW-1:0]     reg_wdata_i, reg_rdata_o, v;
    logic [AW-1:0]     mem_addr_o, inj_addr;
    logic [WORD_W-1:0] mem_wdata_o, mem_rdata_i, e;
    int                num_errors, tests_run, a1, ic;
    integer            seed;
    cspt_core #(.AW(AW), .UV_STOP_CYC(UVC)) dut (.*);
    cspt_store_model #(.AW(AW)) mdl (
        .clk_i(clk_i), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .write_i(mem_write_o),
        .select_i(mem_select_o), .strobe_i(mem_strobe_o), .reset_i(mem_reset_o), .inject_i(inject),
        .inject_addr_i(inj_addr), .rdata_o(mem_rdata_i)
    );
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    function automatic logic [35:0] pat(input int s, input int a);
        logic [31:0] w;
        w = (s == 0) ? 32'hffff_ffff : (s == 1) ? 32'h0000_0000 : WORST_WORD;
        if (s >= 2 && ((a % 2 == 1) != (s == 3)))
            w = ~w;
        return {~^w[31:24], ~^w[23:16], ~^w[15:8], ~^w[7:0], w};
    endfunction : pat
    task automatic chk(input string n, input logic [35:0] x, input logic [35:0] g);
        tests_run++;
        if (g !== x) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rd
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] d;
        rd(a, d);
        chk(n, {4'h0, x}, {4'h0, d});
    endtask : rdchk
    task automatic wait_ev(input int b);
        v = '0;
        for (int i = 0; i < 3000 && v[b] !== 1'b1; i++)
            rd(OFF_IRQ_STAT, v);
        chk("event", 36'h0_0000_0001, 36'(v[b]));
    endtask : wait_ev
    task automatic inj(input int a);
        @(posedge clk_i);
        inject   <= 1'b1;
        inj_addr <= AW'(a);
        @(posedge clk_i);
        inject   <= 1'b0;
    endtask : inj
    task automatic stop_scan;
        wr(OFF_CMD, 32'h0000_0002);
        repeat (20) @(posedge clk_i);
    endtask : stop_scan
    task automatic complete_run;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        complete_run();
    end
    initial begin
        seed = 32'h8cd6_09c2;
        rst_i = 1'b1;
        {reg_wr_i, reg_rd_i, uv6_i, inject} = '0;
        reg_addr_i = '0;
        reg_wdata_i = '0;
        inj_addr = '0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("ctrl_reset", OFF_CTRL, 32'(CTRL_RESET));
        rdchk("unmapped", 8'h30, 32'h0000_0000);
        wr(OFF_CMD, 32'h0000_0001);
        rdchk("process_refuse", OFF_STATUS, 32'h0000_0000);
        wr(OFF_IRQ_EN, 32'h0000_000f);
        for (int p = 0; p < 4; p++) begin
            wr(OFF_CTRL, 32'(p) | 32'h0000_0008);
            wr(OFF_IRQ_CLR, 32'h0000_000f);
            wr(OFF_CMD, 32'h0000_0001);
            #1 chk("light", 36'h0_0000_0001, 36'(test_light_o));
            wait_ev(EV_PASS);
            rdchk("sdr_ones", OFF_SDR_DATA, 32'hffff_ffff);
            stop_scan();
            for (int a = 0; a < NW; a++)
                chk("written", pat(p, a), mdl.mem[a]);
            wr(OFF_CTRL, 32'(p));
            wr(OFF_IRQ_CLR, 32'h0000_000f);
            wr(OFF_CMD, 32'h0000_0001);
            wait_ev(EV_PASS);
            stop_scan();
            rdchk("clean_pass", OFF_IRQ_STAT, 32'h0000_0004);
            for (int a = 0; a < NW; a++)
                chk("regen", pat(p, a), mdl.mem[a]);
        end
        a1 = 1 + ($unsigned($random(seed)) % 40);
        e = pat(3, a1);
        inj(a1);
        inj(NW - 1);
        wr(OFF_CTRL, 32'h0000_0013);
        wr(OFF_IRQ_CLR, 32'h0000_000f);
        wr(OFF_CMD, 32'h0000_0001);
        wait_ev(EV_HALT);
        rdchk("iar", OFF_IAR, 32'(a1));
        rdchk("sar", OFF_SAR, 32'(a1));
        rdchk("sdr_bad", OFF_SDR_DATA, e[31:0] ^ 32'h0000_0001);
        rdchk("sdr_par", OFF_SDR_PAR, 32'(e[35:32]));
        rdchk("irq_stat", OFF_IRQ_STAT, 32'h0000_0003);
        #1 chk("irq_on", 36'h0_0000_0001, 36'(irq_o));
        wr(OFF_IRQ_EN, 32'h0000_0000);
        repeat (2) @(posedge clk_i);
        #1 chk("irq_mask", 36'h0_0000_0000, 36'(irq_o));
        wr(OFF_IRQ_CLR, 32'h0000_000f);
        wr(OFF_IRQ_EN, 32'h0000_000f);
        repeat (2) @(posedge clk_i);
        #1 chk("irq_clear", 36'h0_0000_0000, 36'(irq_o));
        wr(OFF_CMD, 32'h0000_0001);
        wait_ev(EV_HALT);
        rdchk("iar_next", OFF_IAR, 32'(NW - 1));
        stop_scan();
        ic = 32 + ($unsigned($random(seed)) % 32);
        wr(OFF_CTRL, 32'h0000_0064);
        wr(OFF_ROUTINE, 32'h0000_00ca);
        wr(OFF_IC, 32'(ic));
        rdchk("routine", OFF_ROUTINE, 32'h0000_00ca);
        wr(OFF_CMD, 32'h0000_0001);
        repeat (4) begin
            repeat (13) @(posedge clk_i);
            rdchk("loop_sar", OFF_SAR, 32'(ic - 32));
        end
        rdchk("loop_stat", OFF_STATUS, 32'h0000_000a);
        stop_scan();
        wr(OFF_CTRL, 32'h0000_0000);
        wr(OFF_IRQ_CLR, 32'h0000_000f);
        wr(OFF_CMD, 32'h0000_0001);
        repeat (30) @(posedge clk_i);
        uv6_i <= 1'b1;
        for (int i = 0; i < UVC + 20 && power_drop_o !== 1'b1; i++)
            @(posedge clk_i);
        #1 chk("power_drop", 36'h0_0000_0001, 36'(power_drop_o));
        repeat (15) @(posedge clk_i);
        v = '0;
        repeat (30) @(posedge clk_i) v[0] = v[0] | mem_select_o;
        chk("cycling", 36'h0_0000_0000, 36'(v[0]));
        rd(OFF_STATUS, v);
        chk("pwr_stat", 36'h0_0000_0001, 36'(v[STAT_PWR_BIT]));
        rd(OFF_IRQ_STAT, v);
        chk("uv_event", 36'h0_0000_0001, 36'(v[EV_UV]));
        complete_run();
    end
endmodule : cspt_core_tb_top
